// ===== logic/abs_pkg.sv
// package: constants and carrier structs for the backplane bus master
package abs_pkg;
    localparam int ABS_DATA_W      = 16;
    localparam int ABS_ADDR_W      = 16;
    localparam int ABS_REPLY_WAIT  = 255;
    localparam logic [15:0] ABS_BANK_BASE = 16'he000;
    localparam logic [7:0]  ABS_SETUP_CYC = 8'h02;
    localparam logic [7:0]  ABS_TIMEOUT_CYC = 8'hff;

    typedef enum logic [1:0]
    {
        ABS_OP_READ  = 2'b00,
        ABS_OP_WRITE = 2'b01,
        ABS_OP_BYTE  = 2'b10,
        ABS_OP_VEC   = 2'b11
    } abs_op_e;

    typedef struct packed
    {
        abs_op_e     op;
        logic [15:0] addr;
        logic [15:0] wdata;
    } abs_req_s;

    typedef struct packed
    {
        logic [15:0] rdata;
        logic        timeout;
    } abs_rsp_s;

    typedef struct packed
    {
        logic sync_n;
        logic din_n;
        logic dout_n;
        logic wtbt_n;
        logic bs7_n;
        logic iak_n;
        logic init_n;
    } abs_ctl_s;
endpackage : abs_pkg

// ===== logic/abs_master.sv
// bus master that drives the asynchronous multiplexed backplane bus
// Notes on behaviour
// - sixteen shared lines carry address then data, bit 0 least significant
// - master asserts address strobe with valid address and holds it all transfer
// - master asserts data-in under address strobe when ready, waits for reply
// - master answers a request with data-in plus interrupt acknowledge
// - master asserts byte control in address phase before an output cycle
// - master asserts byte control in data phase of a byte output
// - master asserts bank select for the upper 8K bank, held with strobe
`timescale 1ns/1ns
module abs_master
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 req_valid,
    input  wire abs_pkg::abs_req_s    req,
    output logic                      req_ready,
    output logic                      rsp_valid,
    output abs_pkg::abs_rsp_s         rsp,
    input  wire logic                 irq_ack_enable,
    output logic                      irq_pending,
    output logic                      init_request_ack,
    input  wire logic                 init_request,
    input  wire logic [15:0]          bus_dal_n_in,
    output logic [15:0]               bus_dal_n_out,
    output logic [15:0]               bus_dal_oe,
    output abs_pkg::abs_ctl_s         bus_ctl,
    input  wire logic                 slave_reply_n,
    input  wire logic                 interrupt_request_line_n
);
    import abs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0]
    {
        ABS_IDLE  = 3'b000,
        ABS_ADDR  = 3'b001,
        ABS_DATA  = 3'b010,
        ABS_WAIT  = 3'b011,
        ABS_END   = 3'b100,
        ABS_INIT  = 3'b101
    } abs_state_e;

    abs_state_e  state_ff;
    abs_state_e  nxt_state;
    abs_req_s    req_ff;
    logic [7:0]  cnt_ff;
    logic [7:0]  nxt_cnt;
    logic        reply_seen;
    logic        cnt_done;
    logic        is_write;
    logic        is_vec;
    logic        upper_bank;
    logic        start_ok;
    logic        addr_strobe_on;
    logic        bank_on;
    logic        byte_ctl_on;

    // lines are active low: asserted means electrical low
    assign reply_seen = ~slave_reply_n;
    assign cnt_done   = (cnt_ff == ABS_SETUP_CYC);
    assign is_write   = (req_ff.op == ABS_OP_WRITE) || (req_ff.op == ABS_OP_BYTE);
    assign is_vec     = (req_ff.op == ABS_OP_VEC);
    assign upper_bank = (req_ff.addr >= ABS_BANK_BASE);
    // a vector fetch is only started while a slave requests service
    assign start_ok   = req_valid && state_ff == ABS_IDLE &&
                        (req.op != ABS_OP_VEC || (irq_ack_enable && ~interrupt_request_line_n));
    // strobe trails the address by one cycle so a slave latches a settled value
    assign addr_strobe_on = (state_ff == ABS_ADDR && cnt_ff != 8'h00) ||
                            ((nxt_state == ABS_DATA || nxt_state == ABS_WAIT) &&
                             !is_vec && state_ff != ABS_IDLE);
    // bank select comes up with the address and drops with the strobe
    assign bank_on        = upper_bank && !is_vec && state_ff != ABS_IDLE &&
                            (nxt_state == ABS_ADDR || nxt_state == ABS_DATA ||
                             nxt_state == ABS_WAIT);
    // byte control marks any write in the address phase, only a byte write after
    assign byte_ctl_on    = (nxt_state == ABS_ADDR && is_write && state_ff != ABS_IDLE) ||
                            (req_ff.op == ABS_OP_BYTE && state_ff != ABS_IDLE &&
                             (nxt_state == ABS_DATA || nxt_state == ABS_WAIT));

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff + 8'h01;
        case (state_ff)
            ABS_IDLE:
            begin
                nxt_cnt = 8'h00;
                // init outranks a waiting request
                if (init_request)
                    nxt_state = ABS_INIT;
                else if (start_ok)
                    nxt_state = (req.op == ABS_OP_VEC) ? ABS_DATA : ABS_ADDR;
            end
            ABS_ADDR:
            begin
                if (cnt_done)
                begin
                    nxt_state = ABS_DATA;
                    nxt_cnt   = 8'h00;
                end
            end
            ABS_DATA:
            begin
                // data lines settle before the data strobe goes out
                if (cnt_done)
                begin
                    nxt_state = ABS_WAIT;
                    nxt_cnt   = 8'h00;
                end
            end
            ABS_WAIT:
            begin
                // a transfer completes on reply or on timeout; timeout avoids a hung bus
                if (reply_seen || cnt_ff == ABS_TIMEOUT_CYC)
                begin
                    nxt_state = ABS_END;
                    nxt_cnt   = 8'h00;
                end
            end
            ABS_END:
            begin
                // strobes dropped; wait for reply to be released
                // a reply stuck low must not hang the master, so the same limit applies
                if (!reply_seen || cnt_ff == ABS_TIMEOUT_CYC)
                    nxt_state = ABS_IDLE;
            end
            ABS_INIT:
            begin
                if (cnt_done)
                    nxt_state = ABS_IDLE;
            end
            default:
                nxt_state = ABS_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff <= ABS_IDLE;
            cnt_ff   <= 8'h00;
            req_ff   <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            if (start_ok && !init_request)
                req_ff <= req;
        end
    end

    // bus drive, all registered
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bus_dal_n_out    <= 16'hffff;
            bus_dal_oe       <= 16'h0000;
            bus_ctl          <= '1;
            req_ready        <= 1'b0;
            rsp_valid        <= 1'b0;
            rsp              <= '0;
            irq_pending      <= 1'b0;
            init_request_ack <= 1'b0;
        end
        else
        begin
            irq_pending      <= ~interrupt_request_line_n;
            // ready stays low while an init is pending so no request slips in
            req_ready        <= (nxt_state == ABS_IDLE) && !init_request;
            rsp_valid        <= 1'b0;
            init_request_ack <= (state_ff == ABS_INIT) && cnt_done;
            bus_ctl.init_n   <= ~(nxt_state == ABS_INIT);
            // address goes out one cycle ahead of the strobe
            bus_ctl.sync_n   <= ~addr_strobe_on;
            bus_ctl.bs7_n    <= ~bank_on;
            bus_ctl.wtbt_n   <= ~byte_ctl_on;
            bus_ctl.din_n    <= ~(nxt_state == ABS_WAIT && !is_write);
            bus_ctl.iak_n    <= ~(nxt_state == ABS_WAIT && is_vec);
            bus_ctl.dout_n   <= ~(nxt_state == ABS_WAIT && is_write);
            // lines float for reads and vector fetches so the slave can drive them
            if (state_ff == ABS_ADDR)
            begin
                bus_dal_n_out <= ~req_ff.addr;
                bus_dal_oe    <= 16'hffff;
            end
            else if ((state_ff == ABS_DATA || state_ff == ABS_WAIT) && is_write)
            begin
                bus_dal_n_out <= ~req_ff.wdata;
                bus_dal_oe    <= 16'hffff;
            end
            else
            begin
                bus_dal_n_out <= 16'hffff;
                bus_dal_oe    <= 16'h0000;
            end
            if (state_ff == ABS_WAIT && nxt_state == ABS_END)
            begin
                rsp_valid     <= 1'b1;
                rsp.rdata     <= is_write ? 16'h0000 : ~bus_dal_n_in;
                rsp.timeout   <= !reply_seen;
            end
        end
    end
endmodule : abs_master

// ===== tb/abs_chk_asserts.sv
// checker: bus master handshake properties
`timescale 1ns/1ns
module abs_chk
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              req_ready,
    input wire logic [15:0]       bus_dal_n_out,
    input wire logic [15:0]       bus_dal_oe,
    input wire abs_pkg::abs_ctl_s bus_ctl,
    input wire logic              slave_reply_n
);
    import abs_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_din_with_sync: assert property (!bus_ctl.din_n && bus_ctl.iak_n |-> !bus_ctl.sync_n)
        else $error("din without sync");
    a_dout_with_sync: assert property (!bus_ctl.dout_n |-> !bus_ctl.sync_n)
        else $error("dout without sync");
    a_dout_data_on: assert property (!bus_ctl.dout_n |-> bus_dal_oe == 16'hffff)
        else $error("dout without data");
    a_vec_has_ack: assert property (!bus_ctl.din_n && bus_ctl.sync_n |-> !bus_ctl.iak_n)
        else $error("vector without ack");
    a_bank_sel_set: assert property ($fell(bus_ctl.sync_n) |->
        bus_ctl.bs7_n == (~bus_dal_n_out < ABS_BANK_BASE)) else $error("bank select");
    a_read_released: assert property (!bus_ctl.din_n |-> bus_dal_oe == 16'h0000)
        else $error("lines driven on input");
    a_idle_all_high: assert property (req_ready |-> bus_ctl == 7'h7f)
        else $error("idle control low");
    a_reply_drops_strb: assert property ($fell(slave_reply_n) |->
        ##[1:8] (bus_ctl.din_n && bus_ctl.dout_n)) else $error("strobe held");
    c_write: cover property ($fell(bus_ctl.dout_n));
    c_vector: cover property (!bus_ctl.din_n && bus_ctl.sync_n);
    c_byte: cover property (!bus_ctl.dout_n && !bus_ctl.wtbt_n);
endmodule : abs_chk
bind abs_master abs_chk u_chk (.clk, .rst, .req_ready, .bus_dal_n_out, .bus_dal_oe,
    .bus_ctl, .slave_reply_n);

// ===== tb/abs_dev.sv
// behavioural peripheral module answering the bus master
`timescale 1ns/1ns
module abs_dev
(
    input wire logic              clk,
    input wire abs_pkg::abs_ctl_s ctl,
    input wire logic [15:0]       dal_n,
    input wire logic [1:0]        mode,
    input wire logic              rq,
    output logic                  reply_n,
    output logic                  irq_n,
    output logic [15:0]           drv_n,
    output logic                  drv_oe
);
    import abs_pkg::*;
    parameter logic [15:0] VEC = 16'h00a4;
    logic [15:0] adr_ff;
    logic [15:0] mem_ff [4];
    int          cnt_ff;
    wire vec  = !ctl.din_n && ctl.sync_n && !ctl.iak_n && rq;
    wire strb = !ctl.dout_n || (!ctl.din_n && (!ctl.sync_n || vec));
    assign irq_n  = !rq;
    assign drv_oe = !ctl.din_n && (vec || !ctl.sync_n);
    assign drv_n  = vec ? ~VEC : ~mem_ff[adr_ff[2:1]];
    always @(negedge ctl.sync_n) adr_ff <= ~dal_n;
    always @(posedge clk)
    begin
        cnt_ff <= strb ? cnt_ff + 1 : 0;
        // mode 2 never answers, so the master must give up on its own
        reply_n <= !(strb && mode != 2 && cnt_ff >= (mode == 1 ? 6 : 1));
        if (!ctl.dout_n && cnt_ff == 1)
            mem_ff[adr_ff[2:1]] <= ~dal_n;
        if (!ctl.init_n)
            mem_ff <= '{default: 16'h0000};
    end
endmodule : abs_dev

// ===== tb/tb.sv
// testbench: random bus traffic against the peripheral model
`timescale 1ns/1ns
module tb;
    import abs_pkg::*;
    localparam logic [15:0] VEC_ADDR = 16'h00a4;
    logic        clk, rst, req_valid, irq_ack_enable, init_request, rq, reply_n, irq_n, drv_oe;
    logic        req_ready, rsp_valid, irq_pending, init_request_ack;
    logic [1:0]  mode;
    logic [15:0] out_n, oe, drv_n, dal_n, lf, ref_mem [4] = '{default: 16'h0000};
    abs_req_s    req;
    abs_rsp_s    rsp;
    abs_ctl_s    ctl;
    int          mismatches, checked, i;
    wire [2:0] st = {init_request_ack, rsp_valid, req_ready};
    // pulled-up wired bus
    assign dal_n = (out_n | ~oe) & (drv_oe ? drv_n : 16'hffff);
    abs_master dut (.clk, .rst, .req_valid, .req, .req_ready, .rsp_valid, .rsp,
        .irq_ack_enable, .irq_pending, .init_request_ack, .init_request,
        .bus_dal_n_in(dal_n), .bus_dal_n_out(out_n), .bus_dal_oe(oe), .bus_ctl(ctl),
        .slave_reply_n(reply_n), .interrupt_request_line_n(irq_n));
    abs_dev #(.VEC(VEC_ADDR)) dev (.clk, .ctl, .dal_n, .mode, .rq, .reply_n, .irq_n,
        .drv_n, .drv_oe);
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(string what, logic [16:0] exp, logic [16:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask : chk
    task automatic stop_test();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    task automatic await(int w);
        for (i = 0; i < 700 && st[w] !== 1'b1; i++)
            @(posedge clk);
        if (i == 700)
        begin
            mismatches++;
            stop_test();
        end
    endtask : await
    task automatic xfer(abs_op_e op, logic [15:0] a, logic [15:0] d);
        await(0);
        req_valid <= 1'b1;
        req       <= '{op, a, d};
        @(posedge clk);
        req_valid <= 1'b0;
        await(1);
    endtask : xfer
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        {rst, req_valid, irq_ack_enable, init_request, rq, mode} = 7'h40;
        req = '0;
        lf  = 16'h000b;
        repeat (2) @(posedge clk);
        rst          <= 1'b0;
        init_request <= 1'b1;
        await(2);
        init_request <= 1'b0;
        xfer(ABS_OP_READ, 16'h0102, 16'h0000);
        chk("read after init", 17'h0_0000, rsp);
        xfer(ABS_OP_BYTE, 16'he000, 16'h1234);
        ref_mem[0] = 16'h1234;
        xfer(ABS_OP_READ, 16'hdff8, 16'h0000);
        chk("bank edge read", {16'h1234, 1'b0}, rsp);
        for (int n = 0; n < 40; n++)
        begin
            lf = lfsr(lf);
            mode <= {1'b0, lf[3]};
            xfer(abs_op_e'(lf[15:14] == 2'b11 ? 2'b00 : lf[15:14]), lf, ~lf);
            if (lf[15] == lf[14])
                chk("read", {ref_mem[lf[2:1]], 1'b0}, rsp);
            else
                chk("write", 17'h0_0000, rsp);
            if (lf[15] != lf[14])
                ref_mem[lf[2:1]] = ~lf;
        end
        mode <= 2'b10;
        xfer(ABS_OP_READ, 16'h0004, 16'h0000);
        chk("timeout", 17'h0_0001, {16'h0000, rsp.timeout});
        mode           <= 2'b00;
        irq_ack_enable <= 1'b1;
        req_valid      <= 1'b1;
        req            <= '{ABS_OP_VEC, 16'h0000, 16'h0000};
        repeat (5) @(posedge clk);
        chk("refused vector", 17'h0_0001, {15'h0000, st[1:0]});
        req_valid <= 1'b0;
        rq        <= 1'b1;
        repeat (3) @(posedge clk);
        chk("irq pending", 17'h0_0001, {16'h0000, irq_pending});
        xfer(ABS_OP_VEC, 16'h0000, 16'h0000);
        chk("vector", {VEC_ADDR, 1'b0}, rsp);
        stop_test();
    end
endmodule : tb
